// [shared/pcdo_consts.svh]
`ifndef PCDO_CONSTS_SVH
`define PCDO_CONSTS_SVH

// register byte offsets
`define PCDO_REG_CTRL      8'h00
`define PCDO_REG_STATUS    8'h04

// control field positions
`define PCDO_SEL_LSB       0
`define PCDO_SEL_MSB       3
`define PCDO_RUN_BIT       4
`define PCDO_BYPASS_BIT    5
`define PCDO_CTRL_RESET    6'h00

// status field positions
`define PCDO_STAT_ACTIVE   0
`define PCDO_STAT_PIN      1

// number of divide-by-two stages
`define PCDO_STAGES        16
`endif

// [shared/pcdo_pkg.sv]
package pcdo_pkg;
    typedef enum logic [1:0] {
        PCDO_IDLE  = 2'b00,
        PCDO_RUN   = 2'b01,
        PCDO_DRAIN = 2'b11
    } pcdo_state_t;
endpackage : pcdo_pkg

// [logic/pcdo_div_chain.sv]
`timescale 1ns/1ps
`include "pcdo_consts.svh"

module pcdo_div_chain #(
    parameter int STAGES = `PCDO_STAGES
) (
    // clock and reset
    input  wire logic              clock_in,
    input  wire logic              rstn_in,
    // control
    input  wire logic              tick_in,
    input  wire logic              count_en_in,
    input  wire logic              clear_in,
    // stage outputs
    output logic [STAGES-1:0]      stages_out
);
    logic [STAGES:0] carry;

    // each stage toggles when every stage below it is high
    assign carry[0] = tick_in & count_en_in;

    genvar k;
    generate
        for (k = 0; k < STAGES; k++) begin : g_stage
            assign carry[k+1] = carry[k] & stages_out[k];
            always_ff @(posedge clock_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    stages_out[k] <= 1'b0;
                end else if (clear_in) begin
                    stages_out[k] <= 1'b0;
                end else if (carry[k]) begin
                    stages_out[k] <= ~stages_out[k];
                end
            end
        end
    endgenerate
endmodule : pcdo_div_chain

// [logic/pcdo_top.sv]
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "pcdo_consts.svh"

module pcdo_top #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              clock_in,
    input  wire logic              rstn_in,
    // register port
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [31:0]       wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    output logic [31:0]            rdata_out,
    // divider input clock, sampled from a pin
    input  wire logic              divider_input_clock_in,
    // divided clock pin
    output logic                   clock_output_pin_out
);
    localparam int STAGES = `PCDO_STAGES;

    logic [3:0]                    divide_select;
    logic                          run;
    logic                          divider_bypass;
    logic [2:0]                    sync;
    logic                          in_level;
    logic                          in_level_d;
    logic                          tick;
    logic [STAGES-1:0]             stages;
    logic                          selected;
    logic                          active;
    logic                          next_pin;
    pcdo_pkg::pcdo_state_t         state;
    pcdo_pkg::pcdo_state_t         next_state;

    // register writes
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            divide_select  <= 4'h0;
            run            <= 1'b0;
            divider_bypass <= 1'b0;
        end else if (wr_in && addr_in == ADDR_W'(`PCDO_REG_CTRL)) begin
            divide_select  <= wdata_in[`PCDO_SEL_MSB:`PCDO_SEL_LSB];
            run            <= wdata_in[`PCDO_RUN_BIT];
            divider_bypass <= wdata_in[`PCDO_BYPASS_BIT];
        end
    end

    // register reads: data stands for exactly the cycle after the strobe
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (!rd_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (addr_in == ADDR_W'(`PCDO_REG_CTRL)) begin
            rdata_out <= {26'h0, divider_bypass, run, divide_select};
        end else if (addr_in == ADDR_W'(`PCDO_REG_STATUS)) begin
            rdata_out <= {30'h0, clock_output_pin_out, active};
        end else begin
            rdata_out <= 32'h0000_0000;
        end
    end

    // three-stage synchroniser; a change counts once stages two and three agree
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync <= 3'h0;
        end else begin
            sync <= {sync[1:0], divider_input_clock_in};
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            in_level   <= 1'b0;
            in_level_d <= 1'b0;
        end else begin
            if (sync[1] == sync[2]) begin
                in_level <= sync[2];
            end
            in_level_d <= in_level;
        end
    end

    // one-cycle pulse per rising edge of the input clock;
    // limits input clock to well under a quarter of clock_in
    assign tick = in_level & ~in_level_d;

    pcdo_div_chain #(
        .STAGES      (STAGES)
    ) u_chain (
        .clock_in    (clock_in),
        .rstn_in     (rstn_in),
        .tick_in     (tick),
        .count_en_in (active),
        .clear_in    (!active),
        .stages_out  (stages)
    );

    // stage N runs at input over 2**(N+1)
    assign selected = stages[divide_select];

    assign active = (state != pcdo_pkg::PCDO_IDLE);

    always_comb begin
        next_state = state;
        case (state)
            pcdo_pkg::PCDO_IDLE: begin
                if (run) begin
                    next_state = pcdo_pkg::PCDO_RUN;
                end
            end
            pcdo_pkg::PCDO_RUN: begin
                if (!run) begin
                    next_state = selected ? pcdo_pkg::PCDO_DRAIN
                                          : pcdo_pkg::PCDO_IDLE;
                end
            end
            pcdo_pkg::PCDO_DRAIN: begin
                if (run) begin
                    next_state = pcdo_pkg::PCDO_RUN;
                end else if (!selected) begin
                    next_state = pcdo_pkg::PCDO_IDLE;
                end
            end
            default: begin
                next_state = pcdo_pkg::PCDO_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= pcdo_pkg::PCDO_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // gated while idle unless bypassed, so a select change cannot raise a stale stage
    always_comb begin
        if (divider_bypass) begin
            next_pin = in_level;
        end else if (active) begin
            next_pin = selected;
        end else begin
            next_pin = 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            clock_output_pin_out <= 1'b0;
        end else begin
            clock_output_pin_out <= next_pin;
        end
    end

    // helper: mask of the stages below the selected one
    logic [STAGES-1:0] low_mask;
    assign low_mask = STAGES'((32'h1 << divide_select) - 32'h1);

    a_stage_halves: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        (tick && active) |=> (stages[0] != $past(stages[0])))
        else $error("first stage did not toggle on input edge");

    a_stage_holds: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        (!tick && active) |=> (stages == $past(stages)))
        else $error("stages moved without an input edge");

    a_pin_follows: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        (active && !divider_bypass) |=>
            (clock_output_pin_out == $past(selected)))
        else $error("pin does not follow selected stage");

    a_select_power: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        (active && tick && ((stages & low_mask) == low_mask)
            && !(wr_in && addr_in == ADDR_W'(`PCDO_REG_CTRL)))
        |=> (selected != $past(selected)))
        else $error("selected stage missed its toggle");

    a_run_starts: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        (state == pcdo_pkg::PCDO_IDLE && wr_in
            && addr_in == ADDR_W'(`PCDO_REG_CTRL)
            && wdata_in[`PCDO_RUN_BIT])
        |-> ##2 (state == pcdo_pkg::PCDO_RUN))
        else $error("run write did not start the chain");

    a_stop_low: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        (active && !run && !selected) |=> !active)
        else $error("chain kept running after output went low");

    a_no_cut: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        (active && !run && selected) |=> active)
        else $error("chain stopped with output high");

    a_bypass_path: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        divider_bypass |=> (clock_output_pin_out == $past(in_level)))
        else $error("bypass does not pass input clock");

    a_idle_low: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        (!active && !divider_bypass) |=> !clock_output_pin_out)
        else $error("pin not low while idle");
endmodule : pcdo_top

// [dv/pcdo_pin_monitor.sv]
`timescale 1ns/1ps
module pcdo_pin_monitor (
    // clock and reset
    input  wire logic   clock_in,
    input  wire logic   rstn_in,
    // pin watched, source clock made
    input  wire logic   clock_output_pin_in,
    output logic        divider_input_clock_out,
    // measurements in clock_in cycles
    output logic [31:0] rise_count_out,
    output logic [31:0] period_out,
    output logic [31:0] high_out
);
    // source at clock_in/8 stays below the clock_in/4 sync limit
    logic [1:0]  phase;
    logic [31:0] now;
    logic [31:0] last_rise;
    logic        pin_q;

    // one process owns the source clock, so it starts from reset, not initial
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            phase                   <= 2'h0;
            divider_input_clock_out <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            if (phase == 2'h3) begin
                divider_input_clock_out <= ~divider_input_clock_out;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            now            <= 32'h0;
            last_rise      <= 32'h0;
            pin_q          <= 1'b0;
            rise_count_out <= 32'h0;
            period_out     <= 32'h0;
            high_out       <= 32'h0;
        end else begin
            now   <= now + 32'h1;
            pin_q <= clock_output_pin_in;
            if (clock_output_pin_in && !pin_q) begin
                rise_count_out <= rise_count_out + 32'h1;
                period_out     <= now - last_rise;
                last_rise      <= now;
            end
            if (!clock_output_pin_in && pin_q) begin
                high_out <= now - last_rise;
            end
        end
    end
endmodule : pcdo_pin_monitor

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
    logic        clock_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic [7:0]  addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    wire  [31:0] rdata_out;
    wire         src_clk;
    wire         pin;
    wire  [31:0] rises;
    wire  [31:0] period;
    wire  [31:0] high;
    int          fails = 0;
    int          check_count = 0;
    int          seed = 32'h6F77;
    int          n;
    int          r;
    int          model_ctrl = 0;

    always #10 clock_in = ~clock_in;

    pcdo_top u_pcdo_top (
        .clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .divider_input_clock_in(src_clk),
        .clock_output_pin_out(pin));

    pcdo_pin_monitor u_pcdo_pin_monitor (
        .clock_in(clock_in), .rstn_in(rstn_in),
        .clock_output_pin_in(pin), .divider_input_clock_out(src_clk),
        .rise_count_out(rises), .period_out(period), .high_out(high));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
        // only six control bits are kept, the rest read zero
        if (a == 8'h00) model_ctrl = d & 32'h3F;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 check(rdata_out, exp);
    endtask : rd

    task automatic wait_rises(input int k);
        int start;
        start = rises;
        for (int i = 0; i < 20000 && rises < start + k; i++) begin
            @(posedge clock_in);
        end
        #1;
    endtask : wait_rises

    task automatic conclude;
        $display("compares %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        #(20 * 60000);
        fails++;
        conclude();
    end

    initial begin
        repeat (12) @(posedge clock_in);
        rstn_in <= 1'b1;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        check(pin, 1'b0);
        rd(8'h40, 32'h0);
        $display("test reset done");
        for (int k = 0; k < 6; k++) begin
            n = (k < 4) ? k : ($random(seed) & 3);
            wr(8'h00, ($random(seed) & 32'hFFFFFFC0) | 32'h10 | n);
            rd(8'h00, model_ctrl);
            wait_rises(3);
            check(period, 8 << (n + 1));
        end
        $display("test divide done");
        // slowest tested stage leaves room to stop in mid-high
        n = 3;
        wr(8'h00, 32'h10 | n);
        for (int i = 0; i < 500 && pin !== 1'b0; i++) begin
            @(posedge clock_in);
            #1;
        end
        for (int i = 0; i < 500 && pin !== 1'b1; i++) begin
            @(posedge clock_in);
            #1;
        end
        rd(8'h04, 32'h3);
        // select kept, or the pulse would be cut by the select change
        wr(8'h00, n);
        repeat (300) @(posedge clock_in);
        #1 check(pin, 1'b0);
        check(high, 4 << (n + 1));
        rd(8'h04, 32'h0);
        r = rises;
        repeat (200) @(posedge clock_in);
        check(rises, r);
        $display("test stop done");
        wr(8'h00, 32'h20);
        wait_rises(3);
        check(period, 32'h8);
        check(high, 32'h4);
        $display("test bypass done");
        conclude();
    end
endmodule : tb
